/* File: hdl/i2cst_brg.sv */
// reloadable 8-bit baud rate generator of the start sequencer
// assumes load and run come from the same clock domain
`timescale 1ns/1ps
`include "i2cst_consts.svh"
module i2cst_brg #(
    parameter int CW = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    i2cst_brg_if.brg bus
);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tout;
    } i2cst_brg_s;

    i2cst_brg_s st_ff;
    i2cst_brg_s nxt_st;

    // ----------------------------------------------------------------
    // down counter, one timeout pulse at zero
    // ----------------------------------------------------------------
    // load wins over run so a reload never loses its value
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tout = 1'b0;
        if (bus.load) begin
            nxt_st.cnt = bus.reload;
        end else if (bus.run) begin
            if (st_ff.cnt == '0) begin
                nxt_st.tout = 1'b1;
                nxt_st.cnt = bus.reload; // self reload, suspended by caller
            end else begin
                nxt_st.cnt = st_ff.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign bus.timeout = st_ff.tout;
endmodule // i2cst_brg

/* File: hdl/i2cst_top.sv */
// start-condition generator of an i2c master, apb register slave
// assumes sda/scl pins are open drain and asynchronous to clk_i
//
// Overview of operation
// - with a start pending and both lines high, the brg is loaded with the reload value and runs.
// - at the brg timeout with both lines still high, sda is pulled low.
// - pulling sda low with scl high sets the start-detected bit of serial_port_status.
// - after the start is formed the brg is reloaded and resumes counting.
// - at the second timeout the request bit clears, the brg stops and sda stays low.
// - both lines low at the beginning sets the bus collision flag and returns to idle.
// - scl low before sda is driven low sets the bus collision flag and returns to idle.
`timescale 1ns/1ps
`include "i2cst_consts.svh"
module i2cst_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    output logic irq_o
);
    typedef struct packed {
        i2cst_pkg::i2cst_state_e state;
        logic start_req;
        logic [7:0] reload;
        logic start_seen;
        logic [`I2CST_IRQ_WIDTH-1:0] irq_stat;
        logic [`I2CST_IRQ_WIDTH-1:0] irq_en;
        logic sda_low;
        logic irq;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic [1:0] sda_sync;
        logic [1:0] scl_sync;
    } i2cst_top_s;

    i2cst_top_s st_ff;
    i2cst_top_s nxt_st;
    i2cst_brg_if brg_bus ();

    logic sda_hi;
    logic scl_hi;
    logic wr_acc;
    logic rd_acc;
    logic brg_load;
    logic brg_run;
    logic [`I2CST_IRQ_WIDTH-1:0] irq_hw;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // address decode is shared by the read and write paths
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = ((a & `I2CST_ADDR_MASK) == r);
    endfunction

    function automatic logic known(input logic [11:0] a);
        known = hit(a, `I2CST_ADDR_CTRL2) || hit(a, `I2CST_ADDR_RELOAD)
            || hit(a, `I2CST_ADDR_STATUS) || hit(a, `I2CST_ADDR_IRQ_STAT)
            || hit(a, `I2CST_ADDR_IRQ_EN) || hit(a, `I2CST_ADDR_IRQ_CLR);
    endfunction

    // second synchroniser stage only; the first is never looked at
    assign sda_hi = st_ff.sda_sync[1];
    assign scl_hi = st_ff.scl_sync[1];
    // access phase taken on the cycle before pready rises
    assign wr_acc = psel_i && penable_i && !st_ff.ready && pwrite_i;
    assign rd_acc = psel_i && penable_i && !st_ff.ready && !pwrite_i;

    // ----------------------------------------------------------------
    // brg control
    // ----------------------------------------------------------------
    // load on entry to each interval, run while an interval is open
    always_comb begin
        brg_load = 1'b0;
        brg_run = 1'b0;
        case (st_ff.state)
            i2cst_pkg::I2CST_IDLE: begin
                brg_load = st_ff.start_req && sda_hi && scl_hi;
            end
            i2cst_pkg::I2CST_WAIT1: begin
                brg_run = 1'b1;
                brg_load = brg_bus.timeout && sda_hi && scl_hi;
            end
            i2cst_pkg::I2CST_HOLD: begin
                brg_run = !brg_bus.timeout;
            end
            default: begin
                brg_run = 1'b0;
            end
        endcase
    end

    assign brg_bus.load = brg_load;
    assign brg_bus.run = brg_run;
    assign brg_bus.reload = st_ff.reload;

    i2cst_brg #(
        .CW(8)
    ) u_brg (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bus(brg_bus)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sda_sync = {st_ff.sda_sync[0], sda_i};
        nxt_st.scl_sync = {st_ff.scl_sync[0], scl_i};
        nxt_st.ready = 1'b0;
        nxt_st.slverr = 1'b0;
        irq_hw = '0;

        // start sequencer
        case (st_ff.state)
            i2cst_pkg::I2CST_IDLE: begin
                if (st_ff.start_req) begin
                    if (sda_hi && scl_hi) begin
                        nxt_st.state = i2cst_pkg::I2CST_WAIT1;
                    end else if (!sda_hi && !scl_hi) begin
                        // both low at the beginning: collision
                        irq_hw[`I2CST_IRQ_COLL_BIT] = 1'b1;
                        nxt_st.start_req = 1'b0;
                    end
                    // one line low only: wait for the bus to free
                end
            end
            i2cst_pkg::I2CST_WAIT1: begin
                if (!scl_hi) begin
                    // scl pulled before our sda edge
                    irq_hw[`I2CST_IRQ_COLL_BIT] = 1'b1;
                    nxt_st.start_req = 1'b0;
                    nxt_st.state = i2cst_pkg::I2CST_IDLE;
                end else if (brg_bus.timeout && sda_hi) begin
                    nxt_st.sda_low = 1'b1;
                    nxt_st.start_seen = 1'b1;
                    nxt_st.state = i2cst_pkg::I2CST_HOLD;
                end else if (brg_bus.timeout) begin
                    // sda taken low by another master: lost the start
                    irq_hw[`I2CST_IRQ_COLL_BIT] = 1'b1;
                    nxt_st.start_req = 1'b0;
                    nxt_st.state = i2cst_pkg::I2CST_IDLE;
                end
            end
            i2cst_pkg::I2CST_HOLD: begin
                if (brg_bus.timeout) begin
                    nxt_st.start_req = 1'b0;
                    irq_hw[`I2CST_IRQ_DONE_BIT] = 1'b1;
                    nxt_st.state = i2cst_pkg::I2CST_IDLE; // sda stays low
                end
            end
            default: begin
                nxt_st.state = i2cst_pkg::I2CST_IDLE;
            end
        endcase
        // sticky event bits, set by the sequencer above
        nxt_st.irq_stat = st_ff.irq_stat | irq_hw;

        // apb writes; a clear loses to a same-cycle hardware set
        if (wr_acc) begin
            if (hit(paddr_i, `I2CST_ADDR_CTRL2)) begin
                // request only honoured while idle
                if (pwdata_i[`I2CST_CTRL2_START_BIT]
                    && st_ff.state == i2cst_pkg::I2CST_IDLE) begin
                    nxt_st.start_req = 1'b1;
                    nxt_st.sda_low = 1'b0;
                    nxt_st.start_seen = 1'b0;
                end
            end
            if (hit(paddr_i, `I2CST_ADDR_RELOAD)) begin
                nxt_st.reload = pwdata_i[7:0];
            end
            if (hit(paddr_i, `I2CST_ADDR_IRQ_EN)) begin
                nxt_st.irq_en = pwdata_i[`I2CST_IRQ_WIDTH-1:0];
            end
            if (hit(paddr_i, `I2CST_ADDR_IRQ_CLR)) begin
                // keep any bit the sequencer set this cycle
                nxt_st.irq_stat = (st_ff.irq_stat & ~pwdata_i[`I2CST_IRQ_WIDTH-1:0]) | irq_hw;
            end
        end

        // apb reads, answered one cycle after the access phase starts
        if (psel_i && penable_i && !st_ff.ready) begin
            nxt_st.ready = 1'b1;
            nxt_st.slverr = !known(paddr_i);
            nxt_st.rdata = 32'h0000_0000;
            if (rd_acc) begin
                if (hit(paddr_i, `I2CST_ADDR_CTRL2)) begin
                    nxt_st.rdata[`I2CST_CTRL2_START_BIT] = st_ff.start_req;
                end
                if (hit(paddr_i, `I2CST_ADDR_RELOAD)) begin
                    nxt_st.rdata[7:0] = st_ff.reload;
                end
                if (hit(paddr_i, `I2CST_ADDR_STATUS)) begin
                    nxt_st.rdata[`I2CST_STAT_START_BIT] = st_ff.start_seen;
                    nxt_st.rdata[`I2CST_STAT_BUSY_BIT] = st_ff.state != i2cst_pkg::I2CST_IDLE;
                    nxt_st.rdata[`I2CST_STAT_SDA_BIT] = sda_hi;
                    nxt_st.rdata[`I2CST_STAT_SCL_BIT] = scl_hi;
                end
                if (hit(paddr_i, `I2CST_ADDR_IRQ_STAT)) begin
                    nxt_st.rdata[`I2CST_IRQ_WIDTH-1:0] = st_ff.irq_stat;
                end
                if (hit(paddr_i, `I2CST_ADDR_IRQ_EN)) begin
                    nxt_st.rdata[`I2CST_IRQ_WIDTH-1:0] = st_ff.irq_en;
                end
            end
        end

        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_en);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.reload <= `I2CST_RELOAD_RST;
            st_ff.irq_stat <= `I2CST_IRQ_RST;
            st_ff.irq_en <= `I2CST_IRQ_RST;
            st_ff.sda_sync <= `I2CST_SYNC_RST;
            st_ff.scl_sync <= `I2CST_SYNC_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // all outputs from flops or tied low; pins only ever pull low
    assign prdata_o = st_ff.rdata;
    assign pready_o = st_ff.ready;
    assign pslverr_o = st_ff.slverr;
    assign sda_o = 1'b0;
    assign sda_oe_o = st_ff.sda_low;
    assign scl_o = 1'b0;
    assign scl_oe_o = 1'b0; // the start sequence never drives scl
    assign irq_o = st_ff.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_load_on_req: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff.state == i2cst_pkg::I2CST_IDLE && st_ff.start_req && sda_hi && scl_hi
        |=> st_ff.state == i2cst_pkg::I2CST_WAIT1)
        else $error("start not begun with lines high");
    a_sda_pull: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff.state == i2cst_pkg::I2CST_WAIT1 && brg_bus.timeout && sda_hi && scl_hi
        |=> sda_oe_o)
        else $error("sda not pulled at first timeout");
    a_start_seen: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(sda_oe_o) |-> st_ff.start_seen)
        else $error("start bit not set with sda low");
    a_reload_two: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(sda_oe_o) |-> st_ff.state == i2cst_pkg::I2CST_HOLD ##[1:260] brg_bus.timeout)
        else $error("second interval never timed out");
    a_req_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff.state == i2cst_pkg::I2CST_HOLD && brg_bus.timeout
        |=> !st_ff.start_req && sda_oe_o && st_ff.state == i2cst_pkg::I2CST_IDLE)
        else $error("request not cleared at end of start");
    a_coll_low: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff.state == i2cst_pkg::I2CST_IDLE && st_ff.start_req && !sda_hi && !scl_hi
        |=> st_ff.irq_stat[`I2CST_IRQ_COLL_BIT] && !st_ff.start_req)
        else $error("collision missed at start");
    a_coll_scl: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff.state == i2cst_pkg::I2CST_WAIT1 && !scl_hi
        |=> st_ff.irq_stat[`I2CST_IRQ_COLL_BIT] && st_ff.state == i2cst_pkg::I2CST_IDLE
        && !sda_oe_o)
        else $error("scl low not flagged as collision");
    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == |(st_ff.irq_stat & st_ff.irq_en))
        else $error("interrupt level wrong");
    c_start_done: cover property (@(posedge clk_i) disable iff (rst_i)
        st_ff.state == i2cst_pkg::I2CST_HOLD && brg_bus.timeout);
    c_coll_low: cover property (@(posedge clk_i) disable iff (rst_i)
        st_ff.state == i2cst_pkg::I2CST_IDLE && st_ff.start_req && !sda_hi && !scl_hi);
    c_coll_scl: cover property (@(posedge clk_i) disable iff (rst_i)
        st_ff.state == i2cst_pkg::I2CST_WAIT1 && !scl_hi);
endmodule // i2cst_top

/* File: inc/i2cst_brg_if.sv */
// carrier between the start sequencer and its baud rate generator
// assumes one clock domain
`timescale 1ns/1ps
interface i2cst_brg_if;
    logic load;
    logic run;
    logic [7:0] reload;
    logic timeout;

    modport ctrl (output load, output run, output reload, input timeout);
    modport brg (input load, input run, input reload, output timeout);
endinterface

/* File: inc/i2cst_consts.svh */
// register offsets, field positions, reset values and address mask of the i2c start generator
// assumes byte-addressed apb with 32-bit words
`ifndef I2CST_CONSTS_SVH
`define I2CST_CONSTS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define I2CST_ADDR_CTRL2 12'h000
`define I2CST_ADDR_RELOAD 12'h004
`define I2CST_ADDR_STATUS 12'h008
`define I2CST_ADDR_IRQ_STAT 12'h00c
`define I2CST_ADDR_IRQ_EN 12'h010
`define I2CST_ADDR_IRQ_CLR 12'h014

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define I2CST_CTRL2_START_BIT 0
`define I2CST_STAT_START_BIT 0
`define I2CST_STAT_BUSY_BIT 1
`define I2CST_STAT_SDA_BIT 2
`define I2CST_STAT_SCL_BIT 3
`define I2CST_IRQ_COLL_BIT 0
`define I2CST_IRQ_DONE_BIT 1
`define I2CST_IRQ_WIDTH 2

// ----------------------------------------------------------------
// reset values and address mask
// ----------------------------------------------------------------
`define I2CST_RELOAD_RST 8'h09
`define I2CST_SYNC_RST 2'h3
`define I2CST_IRQ_RST 2'h0
`define I2CST_ADDR_MASK 12'hfff

`endif

/* File: inc/i2cst_pkg.sv */
// types of the i2c start generator
// assumes nothing of its surroundings
package i2cst_pkg;

    // ----------------------------------------------------------------
    // start sequence states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        I2CST_IDLE = 2'b00,
        I2CST_WAIT1 = 2'b01,
        I2CST_HOLD = 2'b10
    } i2cst_state_e;

endpackage

/* File: verif/i2cst_bus_model.sv */
// behavioural open-drain i2c bus: pull-ups plus the other parties on sda and scl
// assumes the device pulls a line low while its enable is high; one clock domain
`timescale 1ns/1ps
module i2cst_bus_model (
    input wire logic clk_i,
    input wire logic dev_sda_oe_i,
    input wire logic dev_scl_oe_i,
    input wire logic hold_sda_i,
    input wire logic hold_scl_i,
    output logic sda_o,
    output logic scl_o
);
    // ----------------------------------------------------------------
    // other bus parties
    // ----------------------------------------------------------------
    logic other_sda_ff;
    logic other_scl_ff;

    // other parties move just after an edge, never mid-cycle
    always_ff @(posedge clk_i) begin
        other_sda_ff <= hold_sda_i;
        other_scl_ff <= hold_scl_i;
    end

    // ----------------------------------------------------------------
    // wired-and lines
    // ----------------------------------------------------------------
    // a released line returns to its pull-up level, never to the last value
    assign sda_o = !(dev_sda_oe_i || other_sda_ff);
    assign scl_o = !(dev_scl_oe_i || other_scl_ff);
endmodule // i2cst_bus_model

/* File: verif/i2cst_top_tb.sv */
// self-checking bench of the i2c start generator: apb driver, read monitor, bus model
// assumes the design answers apb with pready and pulls sda through sda_oe_o
`timescale 1ns/1ps
`include "i2cst_consts.svh"
module i2cst_top_tb;
    typedef struct packed {logic rd; logic [31:0] data; logic err;} i2cst_note_s;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic sda_line;
    logic scl_line;
    logic sda_oe_o;
    logic scl_oe_o;
    logic sda_pin;
    logic scl_pin;
    logic irq_o;
    logic hold_sda = 1'b0;
    logic hold_scl = 1'b0;
    logic [7:0] rl;
    i2cst_note_s notes[$];
    i2cst_note_s note;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int seed;
    int n;

    always #2 clk_i = ~clk_i;

    i2cst_top i2cst_top_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .sda_i(sda_line), .sda_o(sda_pin), .sda_oe_o(sda_oe_o), .scl_i(scl_line),
        .scl_o(scl_pin),
        .scl_oe_o(scl_oe_o), .irq_o(irq_o));

    i2cst_bus_model i2cst_bus_model_inst (.clk_i(clk_i), .dev_sda_oe_i(sda_oe_o),
        .dev_scl_oe_i(scl_oe_o), .hold_sda_i(hold_sda), .hold_scl_i(hold_scl),
        .sda_o(sda_line), .scl_o(scl_line));

    // ----------------------------------------------------------------
    // compare tasks and closing report
    // ----------------------------------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_range(input string what, input int lo, input int hi, input int got);
        n_checks++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // apb master and cycle counters
    // ----------------------------------------------------------------
    // request held until pready is sampled high; expectation queued first
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic err);
        notes.push_back('{rd: !wr && !err, data: d, err: err});
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wr ? d : 32'h0;
        @(posedge clk_i);
        penable <= 1'b1;
        // no wait limit here: only the hang guard ends a stuck access
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // cycles until sda_oe (sel 0) or irq (sel 1) is seen rising, bounded
    task automatic rise_after(input int sel, output int cnt);
        logic seen_low;
        seen_low = 1'b0;
        cnt = 0;
        do begin
            @(posedge clk_i);
            cnt++;
            if ((sel == 0 ? sda_oe_o : irq_o) === 1'b0) seen_low = 1'b1;
        end while (!(seen_low && (sel == 0 ? sda_oe_o : irq_o) === 1'b1) && cnt < 400);
    endtask

    // read monitor: oldest note against each answer
    always @(posedge clk_i) begin
        if (psel && penable && pready_o === 1'b1) begin
            note = notes.pop_front();
            cmp("pslverr", {31'h0, note.err}, {31'h0, pslverr_o});
            if (note.rd) cmp("prdata", note.data, prdata_o);
        end
    end

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 25583;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        apb(1'b0, `I2CST_ADDR_RELOAD, 32'h9, 1'b0);
        apb(1'b0, `I2CST_ADDR_STATUS, 32'hc, 1'b0);
        apb(1'b0, `I2CST_ADDR_IRQ_STAT, 32'h0, 1'b0);
        apb(1'b0, `I2CST_ADDR_IRQ_CLR, 32'h0, 1'b0);
        apb(1'b0, 12'h018, 32'h0, 1'b1);
        apb(1'b1, 12'h018, 32'hff, 1'b1);
        $display("test reset_map done");
        // both lines held low by another party, interrupt still masked
        hold_sda <= 1'b1;
        hold_scl <= 1'b1;
        repeat (4) @(posedge clk_i);
        apb(1'b1, `I2CST_ADDR_CTRL2, 32'h1, 1'b0);
        repeat (8) @(posedge clk_i);
        apb(1'b0, `I2CST_ADDR_IRQ_STAT, 32'h1, 1'b0);
        apb(1'b0, `I2CST_ADDR_CTRL2, 32'h0, 1'b0);
        cmp("sda_oe", 32'h0, {31'h0, sda_oe_o});
        cmp("irq masked", 32'h0, {31'h0, irq_o});
        apb(1'b1, `I2CST_ADDR_IRQ_EN, 32'h3, 1'b0);
        repeat (3) @(posedge clk_i);
        cmp("irq enabled", 32'h1, {31'h0, irq_o});
        apb(1'b1, `I2CST_ADDR_IRQ_CLR, 32'h1, 1'b0);
        repeat (3) @(posedge clk_i);
        cmp("irq cleared", 32'h0, {31'h0, irq_o});
        hold_sda <= 1'b0;
        hold_scl <= 1'b0;
        $display("test both_low done");
        // a line stolen in the first interval: scl at once, then sda seen at the timeout
        apb(1'b1, `I2CST_ADDR_RELOAD, 32'h40, 1'b0);
        for (int j = 0; j < 2; j++) begin
            repeat (4) @(posedge clk_i);
            apb(1'b1, `I2CST_ADDR_CTRL2, 32'h1, 1'b0);
            repeat (6) @(posedge clk_i);
            hold_scl <= (j == 0);
            hold_sda <= (j == 1);
            // sda theft only shows at the first timeout, about 0x42 cycles in
            repeat (j == 0 ? 10 : 80) @(posedge clk_i);
            cmp("sda_oe", 32'h0, {31'h0, sda_oe_o});
            cmp("irq coll", 32'h1, {31'h0, irq_o});
            apb(1'b0, `I2CST_ADDR_IRQ_STAT, 32'h1, 1'b0);
            apb(1'b0, `I2CST_ADDR_CTRL2, 32'h0, 1'b0);
            hold_scl <= 1'b0;
            hold_sda <= 1'b0;
            apb(1'b1, `I2CST_ADDR_IRQ_CLR, 32'h1, 1'b0);
            $display("test line_stolen %0d done", j);
        end
        // two clean starts with random reload; the second begins with sda held low
        for (int k = 0; k < 2; k++) begin
            rl = 8'h03 + 8'($random(seed) & 32'h7);
            apb(1'b1, `I2CST_ADDR_RELOAD, {24'h0, rl}, 1'b0);
            repeat (3) @(posedge clk_i);
            apb(1'b1, `I2CST_ADDR_CTRL2, 32'h1, 1'b0);
            rise_after(0, n);
            // reload+2 per interval plus sync; the second start waits out our own sda release
            chk_range("first interval", rl + 3, rl + 5, n);
            cmp("scl at start", 32'h1, {31'h0, scl_line});
            rise_after(1, n);
            chk_range("second interval", rl + 2, rl + 2, n);
            apb(1'b0, `I2CST_ADDR_STATUS, 32'h9, 1'b0);
            apb(1'b0, `I2CST_ADDR_CTRL2, 32'h0, 1'b0);
            apb(1'b0, `I2CST_ADDR_IRQ_STAT, 32'h2, 1'b0);
            cmp("sda held", 32'h0, {31'h0, sda_line});
            cmp("pins pull only", 32'h0, {29'h0, sda_pin, scl_pin, scl_oe_o});
            apb(1'b1, `I2CST_ADDR_IRQ_CLR, 32'h2, 1'b0);
            repeat (3) @(posedge clk_i);
            cmp("irq done cleared", 32'h0, {31'h0, irq_o});
            $display("test start %0d done", k);
        end
        repeat (4) @(posedge clk_i);
        finish_test();
    end
endmodule // i2cst_top_tb
